// ===== logic/sfis_pkg.sv
// Constants shared by the supply fault status block.
package sfis_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the APB port)
    // ------------------------------------------------------------
    localparam logic [11:0] SFIS_STS_OFS = 12'h01C;
    localparam logic [11:0] SFIS_IEN_OFS = 12'h020;
    localparam logic [11:0] SFIS_CLR_OFS = 12'h024;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int unsigned SFIS_FLAG_N   = 8;
    localparam int unsigned SFIS_STS_LSB  = 16;
    localparam int unsigned SFIS_IRQ_LSB  = 0;
    localparam int unsigned SFIS_STS_LANE = 2;
    localparam int unsigned SFIS_IRQ_LANE = 0;

    // Flag index inside an eight bit group: over group high, under low.
    localparam int unsigned SFIS_CORE_OV = 7;
    localparam int unsigned SFIS_IO_OV   = 6;
    localparam int unsigned SFIS_MAIN_OV = 5;
    localparam int unsigned SFIS_BAT_OV  = 4;
    localparam int unsigned SFIS_CORE_UV = 3;
    localparam int unsigned SFIS_IO_UV   = 2;
    localparam int unsigned SFIS_MAIN_UV = 1;
    localparam int unsigned SFIS_BAT_UV  = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SFIS_RD_RST  = 32'h0000_0000;
    localparam logic [7:0]  SFIS_IEN_RST = 8'h00;
    localparam logic [7:0]  SFIS_RSV_RD  = 8'h00;

endpackage

// ===== logic/sfis_flag_cell.sv
// One supply fault flag pair: sticky status and edge-triggered interrupt status.
`timescale 1ns/1ps
`default_nettype none

module sfis_flag_cell
(
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic det_i,
    input  wire logic en_i,
    input  wire logic sts_clr_i,
    input  wire logic irq_clr_i,
    output logic      sts_o,
    output logic      irq_o,
    output logic      set_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic prev;
        logic sts;
        logic irq;
    } sfis_cell_t;

    sfis_cell_t cell_reg;
    sfis_cell_t cell_next;
    logic       rise;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        cell_next      = cell_reg;
        cell_next.prev = det_i;
        // A fault that persists raises its interrupt flag only once.
        rise = det_i & ~cell_reg.prev;
        set_o = rise & en_i;
        if (sts_clr_i)
        begin
            cell_next.sts = 1'b0;
        end
        if (det_i)
        begin
            cell_next.sts = 1'b1;
        end
        if (irq_clr_i)
        begin
            cell_next.irq = 1'b0;
        end
        if (set_o)
        begin
            cell_next.irq = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cell_reg <= '0;
        end
        else
        begin
            cell_reg <= cell_next;
        end
    end

    assign sts_o = cell_reg.sts;
    assign irq_o = cell_reg.irq;

endmodule

`default_nettype wire

// ===== logic/sfis_top.sv
// Supply fault status and clear registers behind an APB slave.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Core overvoltage sets status bit 23.
// - I/O overvoltage sets status bit 22.
// - Main supply overvoltage sets status bit 21.
// - Battery overvoltage sets status bit 20.
// - Core undervoltage sets status bit 19.
// - I/O undervoltage sets status bit 18.
// - Main supply undervoltage sets status bit 17.
// - Battery undervoltage sets status bit 16.
// - Overvoltage interrupt flags in bits 7 to 4.
// - Undervoltage interrupt flags in bits 3 to 0.
// - Reserved bits 31:24 and 15:8 read zero.
// - Clear bits 23:16 clear status flags.
// - Writing zero leaves a flag unchanged.
// - Clear bits 7:0 clear interrupt flags.
// - Reset sets all flags and registers zero.
// - Interrupts fire on fault edge only.
// - Each interrupt has its own enable bit.
module sfis_top
    import sfis_pkg::*;
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic [3:0]  OVER_DET_I,
    input  wire logic [3:0]  UNDER_DET_I,
    output logic             SUPPLY_IRQ_O
);

    import sfis_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [31:0] rdata;
        logic        slverr;
        logic [7:0]  ien;
        logic        irq;
    } sfis_state_t;

    sfis_state_t state_reg;
    sfis_state_t state_next;

    logic [7:0]  det;
    logic [7:0]  sts;
    logic [7:0]  irq;
    logic [7:0]  irq_set;
    logic [7:0]  clr_sts;
    logic [7:0]  clr_irq;
    logic        setup;
    logic        wr_fire;
    logic        clr_hit;
    logic        ien_hit;

    // ------------------------------------------------------------
    // Fault inputs
    // ------------------------------------------------------------
    // Bit order core, I/O, main, battery matches both register groups.
    assign det = {OVER_DET_I, UNDER_DET_I};

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // The slave never waits; read data is captured in the setup cycle.
    assign PREADY_O = 1'b1;
    assign setup    = PSEL_I & ~PENABLE_I;
    assign wr_fire  = PSEL_I & PENABLE_I & PWRITE_I;
    assign clr_hit  = wr_fire & (PADDR_I == SFIS_CLR_OFS);
    assign ien_hit  = wr_fire & (PADDR_I == SFIS_IEN_OFS);

    // Only strobed byte lanes clear; a zero bit is no operation.
    assign clr_sts = PWDATA_I[SFIS_STS_LSB +: SFIS_FLAG_N]
                     & {SFIS_FLAG_N{clr_hit & PSTRB_I[SFIS_STS_LANE]}};
    assign clr_irq = PWDATA_I[SFIS_IRQ_LSB +: SFIS_FLAG_N]
                     & {SFIS_FLAG_N{clr_hit & PSTRB_I[SFIS_IRQ_LANE]}};

    // ------------------------------------------------------------
    // Flag cells
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SFIS_FLAG_N; gi++)
        begin : g_flag
            sfis_flag_cell u_cell
            (
                .clk_i     (SYS_CLK_I),
                .arst_n_i  (ARST_N_I),
                .det_i     (det[gi]),
                .en_i      (state_reg.ien[gi]),
                .sts_clr_i (clr_sts[gi]),
                .irq_clr_i (clr_irq[gi]),
                .sts_o     (sts[gi]),
                .irq_o     (irq[gi]),
                .set_o     (irq_set[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        // The request is one cycle wide so a level fault cannot storm the CPU.
        state_next.irq = |irq_set;
        if (ien_hit && PSTRB_I[SFIS_IRQ_LANE])
        begin
            state_next.ien = PWDATA_I[SFIS_IRQ_LSB +: SFIS_FLAG_N];
        end
        if (setup)
        begin
            state_next.rdata  = SFIS_RD_RST;
            state_next.slverr = 1'b0;
            unique case (PADDR_I)
                SFIS_STS_OFS:
                begin
                    state_next.rdata = {SFIS_RSV_RD, sts, SFIS_RSV_RD, irq};
                end
                SFIS_IEN_OFS:
                begin
                    state_next.rdata = {24'h00_0000, state_reg.ien};
                end
                SFIS_CLR_OFS:
                begin
                    // The clear register holds nothing and reads as zero.
                    state_next.rdata = SFIS_RD_RST;
                end
                default:
                begin
                    state_next.slverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_reg.rdata  <= SFIS_RD_RST;
            state_reg.slverr <= 1'b0;
            state_reg.ien    <= SFIS_IEN_RST;
            state_reg.irq    <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign PRDATA_O     = state_reg.rdata;
    assign PSLVERR_O    = state_reg.slverr & PSEL_I & PENABLE_I;
    assign SUPPLY_IRQ_O = state_reg.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [7:0] clr_only;
    logic [7:0] iclr_only;
    logic [7:0] both_sts;
    logic [3:0] set_ov;
    logic [3:0] set_uv;

    assign clr_only  = clr_sts & ~det;
    assign iclr_only = clr_irq & ~irq_set;
    assign both_sts  = clr_sts & det;
    assign set_ov    = irq_set[7:4];
    assign set_uv    = irq_set[3:0];

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    core_ov_sts_a: assert property (det[SFIS_CORE_OV] |=> sts[SFIS_CORE_OV])
        else $error("Core overvoltage did not set its status flag.");
    io_ov_sts_a: assert property (det[SFIS_IO_OV] |=> sts[SFIS_IO_OV])
        else $error("I/O overvoltage did not set its status flag.");
    main_ov_sts_a: assert property (det[SFIS_MAIN_OV] |=> sts[SFIS_MAIN_OV])
        else $error("Main overvoltage did not set its status flag.");
    bat_ov_sts_a: assert property (det[SFIS_BAT_OV] |=> sts[SFIS_BAT_OV])
        else $error("Battery overvoltage did not set its status flag.");
    core_uv_sts_a: assert property (det[SFIS_CORE_UV] |=> sts[SFIS_CORE_UV])
        else $error("Core undervoltage did not set its status flag.");
    io_uv_sts_a: assert property (det[SFIS_IO_UV] |=> sts[SFIS_IO_UV])
        else $error("I/O undervoltage did not set its status flag.");
    main_uv_sts_a: assert property (det[SFIS_MAIN_UV] |=> sts[SFIS_MAIN_UV])
        else $error("Main undervoltage did not set its status flag.");
    bat_uv_sts_a: assert property (det[SFIS_BAT_UV] |=> sts[SFIS_BAT_UV])
        else $error("Battery undervoltage did not set its status flag.");

    ov_irq_set_a: assert property ((set_ov != 4'h0) |=>
        ((irq[7:4] & $past(set_ov)) == $past(set_ov)))
        else $error("Overvoltage interrupt flag not raised.");
    uv_irq_set_a: assert property ((set_uv != 4'h0) |=>
        ((irq[3:0] & $past(set_uv)) == $past(set_uv)))
        else $error("Undervoltage interrupt flag not raised.");

    rsvd_zero_a: assert property ((PSEL_I && PENABLE_I && !PWRITE_I) |->
        (PRDATA_O[31:24] == 8'h00 && PRDATA_O[15:8] == 8'h00))
        else $error("Reserved read bits are not zero.");

    sts_clear_a: assert property ((clr_only != 8'h00) |=>
        ((sts & $past(clr_only)) == 8'h00))
        else $error("Status clear did not take effect.");
    irq_clear_a: assert property ((iclr_only != 8'h00) |=>
        ((irq & $past(iclr_only)) == 8'h00))
        else $error("Interrupt status clear did not take effect.");

    sts_sticky_a: assert property
        ((($past(sts) & ~sts) & ~$past(clr_sts)) == 8'h00)
        else $error("Status flag fell without a clear.");
    irq_sticky_a: assert property
        ((($past(irq) & ~irq) & ~$past(clr_irq)) == 8'h00)
        else $error("Interrupt flag fell without a clear.");

    irq_edge_a: assert property
        (((irq & ~$past(irq)) & ~$past(irq_set)) == 8'h00)
        else $error("Interrupt flag rose without an enabled fault edge.");
    irq_pulse_a: assert property (SUPPLY_IRQ_O == (|$past(irq_set)))
        else $error("Interrupt request does not follow enabled edges.");

    set_wins_a: assert property ((both_sts != 8'h00) |=>
        ((sts & $past(both_sts)) == $past(both_sts)))
        else $error("Fault lost against a same-cycle clear.");

    // ------------------------------------------------------------
    // Per-source interrupt flags
    // ------------------------------------------------------------
    // These start from the detect pins, not from the cell's own edge signal.
    // A wrong bit order in the cell array would slip past checks built on irq_set.
    core_ov_irq_a: assert property
        ((det[SFIS_CORE_OV] && !$past(det[SFIS_CORE_OV]) && state_reg.ien[SFIS_CORE_OV])
        |=> irq[SFIS_CORE_OV])
        else $error("Core overvoltage edge did not raise its interrupt flag.");
    io_ov_irq_a: assert property
        ((det[SFIS_IO_OV] && !$past(det[SFIS_IO_OV]) && state_reg.ien[SFIS_IO_OV])
        |=> irq[SFIS_IO_OV])
        else $error("I/O overvoltage edge did not raise its interrupt flag.");
    main_ov_irq_a: assert property
        ((det[SFIS_MAIN_OV] && !$past(det[SFIS_MAIN_OV]) && state_reg.ien[SFIS_MAIN_OV])
        |=> irq[SFIS_MAIN_OV])
        else $error("Main overvoltage edge did not raise its interrupt flag.");
    bat_ov_irq_a: assert property
        ((det[SFIS_BAT_OV] && !$past(det[SFIS_BAT_OV]) && state_reg.ien[SFIS_BAT_OV])
        |=> irq[SFIS_BAT_OV])
        else $error("Battery overvoltage edge did not raise its interrupt flag.");
    core_uv_irq_a: assert property
        ((det[SFIS_CORE_UV] && !$past(det[SFIS_CORE_UV]) && state_reg.ien[SFIS_CORE_UV])
        |=> irq[SFIS_CORE_UV])
        else $error("Core undervoltage edge did not raise its interrupt flag.");
    io_uv_irq_a: assert property
        ((det[SFIS_IO_UV] && !$past(det[SFIS_IO_UV]) && state_reg.ien[SFIS_IO_UV])
        |=> irq[SFIS_IO_UV])
        else $error("I/O undervoltage edge did not raise its interrupt flag.");
    main_uv_irq_a: assert property
        ((det[SFIS_MAIN_UV] && !$past(det[SFIS_MAIN_UV]) && state_reg.ien[SFIS_MAIN_UV])
        |=> irq[SFIS_MAIN_UV])
        else $error("Main undervoltage edge did not raise its interrupt flag.");
    bat_uv_irq_a: assert property
        ((det[SFIS_BAT_UV] && !$past(det[SFIS_BAT_UV]) && state_reg.ien[SFIS_BAT_UV])
        |=> irq[SFIS_BAT_UV])
        else $error("Battery undervoltage edge did not raise its interrupt flag.");

    // ------------------------------------------------------------
    // Enables and bus side
    // ------------------------------------------------------------
    logic acc_rd;
    logic mapped;

    assign acc_rd = PSEL_I & PENABLE_I & ~PWRITE_I;
    assign mapped = (PADDR_I == SFIS_STS_OFS) | (PADDR_I == SFIS_IEN_OFS)
                    | (PADDR_I == SFIS_CLR_OFS);

    irq_masked_a: assert property
        (((irq & ~$past(irq)) & ~$past(state_reg.ien)) == 8'h00)
        else $error("Interrupt flag rose while its enable was off.");
    req_masked_a: assert property (($past(state_reg.ien) == 8'h00) |-> !SUPPLY_IRQ_O)
        else $error("Interrupt request with every enable off.");
    ien_write_a: assert property ((ien_hit && PSTRB_I[SFIS_IRQ_LANE]) |=>
        (state_reg.ien == $past(PWDATA_I[SFIS_IRQ_LSB +: SFIS_FLAG_N])))
        else $error("Enable write did not land.");
    ien_keep_a: assert property ((!ien_hit || !PSTRB_I[SFIS_IRQ_LANE]) |=>
        $stable(state_reg.ien))
        else $error("Enable register changed without a strobed write.");
    sts_lane_a: assert property ((clr_hit && !PSTRB_I[SFIS_STS_LANE]) |=>
        (($past(sts) & ~sts) == 8'h00))
        else $error("Status flag cleared through a disabled byte lane.");
    irq_lane_a: assert property ((clr_hit && !PSTRB_I[SFIS_IRQ_LANE]) |=>
        (($past(irq) & ~irq) == 8'h00))
        else $error("Interrupt flag cleared through a disabled byte lane.");
    sts_wr_ign_a: assert property ((wr_fire && PADDR_I == SFIS_STS_OFS) |=>
        ((($past(sts) & ~sts) | ($past(irq) & ~irq)) == 8'h00))
        else $error("A write to the status register cleared a flag.");

    // Read data is captured a cycle early, so it shows the flags as they stood at setup.
    sts_read_a: assert property ((acc_rd && PADDR_I == SFIS_STS_OFS) |->
        (PRDATA_O == {SFIS_RSV_RD, $past(sts), SFIS_RSV_RD, $past(irq)}))
        else $error("Status read does not show the flags.");
    clr_read_a: assert property ((acc_rd && PADDR_I == SFIS_CLR_OFS) |->
        (PRDATA_O == 32'h0000_0000))
        else $error("Clear register read is not zero.");
    unmapped_rd_a: assert property ((acc_rd && !mapped) |->
        (PRDATA_O == 32'h0000_0000))
        else $error("Unmapped read returned data.");
    unmapped_err_a: assert property ((PSEL_I && PENABLE_I && !mapped) |-> PSLVERR_O)
        else $error("Unmapped access gave no error.");
    mapped_ok_a: assert property ((PSEL_I && PENABLE_I && mapped) |-> !PSLVERR_O)
        else $error("Mapped access gave an error.");
    err_idle_a: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O)
        else $error("Error response outside an access phase.");
    ready_high_a: assert property (PREADY_O)
        else $error("Slave inserted a wait state.");
    rdata_hold_a: assert property ((PSEL_I && PENABLE_I) |=> $stable(PRDATA_O))
        else $error("Read data moved after the access phase.");

    irq_seen_c: cover property (|irq_set);
    clr_write_c: cover property (clr_hit && (clr_irq != 8'h00));
    race_c: cover property (both_sts != 8'h00);
    err_c: cover property (PSLVERR_O);
    irq_race_c: cover property ((clr_irq & irq_set) != 8'h00);

endmodule

`default_nettype wire

// ===== sim/sfis_monitor_model.sv
// Behavioural model of the supply monitor that feeds the fault detect levels.
`timescale 1ns/1ps
`default_nettype none

module sfis_monitor_model
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] fault_i,
    output logic      [3:0] over_o,
    output logic      [3:0] under_o
);
    // Levels move only after a clock edge, as a synchronised comparator output would.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            over_o  <= 4'h0;
            under_o <= 4'h0;
        end
        else
        begin
            over_o  <= fault_i[7:4];
            under_o <= fault_i[3:0];
        end
    end
endmodule

`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the supply fault status block.
`timescale 1ns/1ps
`default_nettype none

module tb
    import sfis_pkg::*;
;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  fault = 8'h00;
    logic [3:0]  over;
    logic [3:0]  under;
    logic        irq;
    int          bad_count = 0;
    int          checks_done = 0;
    int          pulses = 0;

    always #4 clk = ~clk;

    sfis_top uut (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .OVER_DET_I(over),
        .UNDER_DET_I(under), .SUPPLY_IRQ_O(irq));

    sfis_monitor_model monitor (.clk_i(clk), .arst_n_i(arst_n), .fault_i(fault),
        .over_o(over), .under_o(under));

    // Interrupt requests are pulses, so they are counted rather than sampled.
    always @(posedge clk)
    begin
        if (irq === 1'b1)
            pulses++;
    end

    task automatic results();
        $display("checks=%0d errors=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic exp_err, output logic [31:0] q);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        q = prdata;
        chk({31'h0000_0000, pslverr}, {31'h0000_0000, exp_err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        apb(1'b1, a, d, s, 1'b0, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, 4'h0, exp_err, q);
        chk(q, exp);
    endtask

    // The monitor adds one cycle and the block one more; three edges leave margin.
    task automatic set_fault(input logic [7:0] f);
        @(posedge clk);
        fault <= f;
        repeat (3) @(posedge clk);
    endtask

    task automatic each_flag();
        int p0;
        wr(SFIS_IEN_OFS, 32'h0000_00FF, 4'h1);
        for (int i = 0; i < 8; i++)
        begin
            p0 = pulses;
            set_fault(8'h01 << i);
            rd(SFIS_STS_OFS, (32'h0000_0001 << (16 + i)) | (32'h0000_0001 << i), 1'b0);
            repeat (4) @(posedge clk);
            chk(32'(pulses - p0), 32'h0000_0001);
            set_fault(8'h00);
            rd(SFIS_STS_OFS, (32'h0000_0001 << (16 + i)) | (32'h0000_0001 << i), 1'b0);
            wr(SFIS_CLR_OFS, 32'h0000_0001 << (16 + i), 4'hF);
            rd(SFIS_STS_OFS, 32'h0000_0001 << i, 1'b0);
            wr(SFIS_CLR_OFS, 32'h0000_0001 << i, 4'hF);
            rd(SFIS_STS_OFS, 32'h0000_0000, 1'b0);
        end
    endtask

    task automatic masked_and_held();
        int p0;
        wr(SFIS_IEN_OFS, 32'h0000_0000, 4'h1);
        p0 = pulses;
        set_fault(8'h01);
        rd(SFIS_STS_OFS, 32'h0001_0000, 1'b0);
        chk(32'(pulses - p0), 32'h0000_0000);
        wr(SFIS_CLR_OFS, 32'h0001_0001, 4'hF);
        rd(SFIS_STS_OFS, 32'h0001_0000, 1'b0);
        set_fault(8'h00);
        wr(SFIS_CLR_OFS, 32'h0001_0000, 4'h1);
        rd(SFIS_STS_OFS, 32'h0001_0000, 1'b0);
        wr(SFIS_CLR_OFS, 32'h0001_0000, 4'h4);
        rd(SFIS_STS_OFS, 32'h0000_0000, 1'b0);
    endtask

    task automatic bus_map();
        wr(SFIS_STS_OFS, 32'hFFFF_FFFF, 4'hF);
        rd(SFIS_STS_OFS, 32'h0000_0000, 1'b0);
        wr(SFIS_IEN_OFS, 32'hFFFF_FFFF, 4'hF);
        rd(SFIS_IEN_OFS, 32'h0000_00FF, 1'b0);
        rd(SFIS_CLR_OFS, 32'h0000_0000, 1'b0);
        rd(12'h028, 32'h0000_0000, 1'b1);
    endtask

    // An enabled fault edge and an interrupt clear land on one edge; the fault must win.
    task automatic clear_race();
        wr(SFIS_IEN_OFS, 32'h0000_00FF, 4'h1);
        @(posedge clk);
        fault   <= 8'h40;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= 1'b1;
        paddr   <= SFIS_CLR_OFS;
        pwdata  <= 32'h0040_0040;
        pstrb   <= 4'hF;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        rd(SFIS_STS_OFS, 32'h0040_0040, 1'b0);
        wr(SFIS_CLR_OFS, 32'h0000_0040, 4'h1);
        rd(SFIS_STS_OFS, 32'h0040_0000, 1'b0);
        set_fault(8'h00);
        wr(SFIS_CLR_OFS, 32'h0040_0000, 4'hF);
        rd(SFIS_STS_OFS, 32'h0000_0000, 1'b0);
    endtask

    // A second reset with flags and enables set must bring everything back to zero.
    task automatic reset_again();
        set_fault(8'h80);
        set_fault(8'h00);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rd(SFIS_STS_OFS, 32'h0000_0000, 1'b0);
        rd(SFIS_IEN_OFS, 32'h0000_0000, 1'b0);
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(SFIS_STS_OFS, 32'h0000_0000, 1'b0);
        rd(SFIS_CLR_OFS, 32'h0000_0000, 1'b0);
        each_flag();
        masked_and_held();
        bus_map();
        clear_race();
        reset_again();
        results();
    end

    // The whole sequence needs well under 1500 cycles.
    initial
    begin
        #50000;
        bad_count++;
        results();
    end
endmodule

`default_nettype wire
